// >>> src/dau_pkg.sv
// constants, register map and field layout for the alu and bit unit
// Notes on behaviour
// RQ1: alu works on 40 bits; 8-bit extension used by arithmetic only.
// RQ2: left operand is shifter output, right operand a register-file register.
// RQ3: logical ops zero-extend 32-bit operands; destination extension byte cleared.
// RQ4: an accumulator operand feeds all 40 bits to arithmetic.
// RQ5: other 32-bit operands sign-extend; 40-bit result goes to one accumulator.
// RQ6: ops update accumulator and flags; some codes update only one of them.
// RQ7: codes take two sources, one source, or one register read and written.
// RQ8: division step codes do non-restoring add or subtract, signed or unsigned.
// RQ9: software puts 32-bit dividend, sign-extended, in an accumulator first.
// RQ10: software puts 16-bit divisor in a right register with long bit clear.
// RQ11: software keeps dividend magnitude below divisor magnitude, both fractional.
// RQ12: saturated signed fractional most-negative squared gives largest positive product.
// RQ13: with 32 or 40-bit saturation, overflow clamps accumulator to that maximum.
// RQ14: rounded multiply stores two's complement rounded product in product-high.
// RQ15: accumulator rounding is two's complement or convergent by rounding-mode bit.
// RQ16: bit unit reaches 16-bit data by direct, indirect or register addressing; direct and indirect both use the bit data register.
// RQ17: masked test low, test high, test high then set, test low then clear.
// RQ18: 8-bit mask widens to upper byte, lower byte, or both bytes.
// RQ19: registers narrower than 16 bits are sign-extended before testing.
// RQ20: accumulator is extension, high and low fields, each addressable alone.
// RQ21: without saturation overflow wraps modulo two to the fortieth.
package dau_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned ACC_W = 40;
	localparam int unsigned WORD_W = 32;
	localparam int unsigned EXT_W = 8;
	localparam int unsigned HALF_W = 16;
	localparam int unsigned SHC_W = 6;
	localparam int unsigned CTRL_W = 6;
	localparam int unsigned CMD_W = 8;
	localparam int unsigned CCR_W = 6;
	localparam int unsigned OP_W = 4;
	localparam int unsigned BC_W = 16;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_SHIFT_LO = 8'h08;
	localparam logic [7:0] OFF_SHIFT_EXT = 8'h0c;
	localparam logic [7:0] OFF_RIGHT0 = 8'h10;
	localparam logic [7:0] OFF_RIGHT1 = 8'h14;
	localparam logic [7:0] OFF_ACC0_EXT = 8'h18;
	localparam logic [7:0] OFF_ACC0_HI = 8'h1c;
	localparam logic [7:0] OFF_ACC0_LO = 8'h20;
	localparam logic [7:0] OFF_ACC1_EXT = 8'h24;
	localparam logic [7:0] OFF_ACC1_HI = 8'h28;
	localparam logic [7:0] OFF_ACC1_LO = 8'h2c;
	localparam logic [7:0] OFF_CCR = 8'h30;
	localparam logic [7:0] OFF_PRODUCT = 8'h34;
	localparam logic [7:0] OFF_PROD_HIGH = 8'h38;
	localparam logic [7:0] OFF_SHIFT_CTRL = 8'h3c;
	localparam logic [7:0] OFF_PROD_SHIFT = 8'h40;
	localparam logic [7:0] OFF_MUL_OPS = 8'h44;
	localparam logic [7:0] OFF_BIT_DATA = 8'h48;
	localparam logic [7:0] OFF_BIT_CMD = 8'h4c;
	// control bits
	localparam int unsigned CTRL_SAT_EN = 0;
	localparam int unsigned CTRL_SAT_WIDTH = 1;
	localparam int unsigned CTRL_RND_MODE = 2;
	localparam int unsigned CTRL_RIGHT_LONG = 3;
	localparam int unsigned CTRL_MUL_SIGNED = 4;
	localparam int unsigned CTRL_MUL_INT = 5;
	// command fields
	localparam int unsigned CMD_OP_LSB = 0;
	localparam int unsigned CMD_DEST = 4;
	localparam int unsigned CMD_RSEL_LSB = 5;
	localparam int unsigned CMD_LEFT_ACC = 7;
	localparam logic [3:0] OP_ADD = 4'h0;
	localparam logic [3:0] OP_SUB = 4'h1;
	localparam logic [3:0] OP_AND = 4'h2;
	localparam logic [3:0] OP_OR = 4'h3;
	localparam logic [3:0] OP_XOR = 4'h4;
	localparam logic [3:0] OP_CMP = 4'h5;
	localparam logic [3:0] OP_MOVE = 4'h6;
	localparam logic [3:0] OP_NEG = 4'h7;
	localparam logic [3:0] OP_ABS = 4'h8;
	localparam logic [3:0] OP_NOT = 4'h9;
	localparam logic [3:0] OP_RND = 4'ha;
	localparam logic [3:0] OP_DIVS = 4'hb;
	localparam logic [3:0] OP_DIVU = 4'hc;
	localparam logic [3:0] OP_MUL = 4'hd;
	localparam logic [3:0] OP_MULR = 4'he;
	// flag bits
	localparam int unsigned CCR_CARRY = 0;
	localparam int unsigned CCR_OVF = 1;
	localparam int unsigned CCR_ZERO = 2;
	localparam int unsigned CCR_NEG = 3;
	localparam int unsigned CCR_TEST = 4;
	localparam int unsigned CCR_LIMIT = 5;
	// bit unit command fields and codes
	localparam int unsigned BC_MASK_LSB = 0;
	localparam int unsigned BC_MMODE_LSB = 8;
	localparam int unsigned BC_OP_LSB = 10;
	localparam int unsigned BC_AMODE_LSB = 12;
	localparam int unsigned BC_RSEL_LSB = 14;
	localparam logic [1:0] MASK_HIGH = 2'h0;
	localparam logic [1:0] MASK_LOW = 2'h1;
	localparam logic [1:0] MASK_BOTH = 2'h2;
	localparam logic [1:0] BOP_TEST_LOW = 2'h0;
	localparam logic [1:0] BOP_TEST_HIGH = 2'h1;
	localparam logic [1:0] BOP_HIGH_SET = 2'h2;
	localparam logic [1:0] BOP_LOW_CLEAR = 2'h3;
	localparam logic [1:0] AMODE_DIRECT = 2'h0;
	localparam logic [1:0] AMODE_INDIRECT = 2'h1;
	localparam logic [1:0] AMODE_REGISTER = 2'h2;
	localparam logic [1:0] BREG_ACC0_EXT = 2'h0;
	localparam logic [1:0] BREG_ACC1_EXT = 2'h1;
	localparam logic [1:0] BREG_SHIFT_CTRL = 2'h2;
	localparam logic [1:0] BREG_PROD_SHIFT = 2'h3;
	// arithmetic constants
	localparam logic [39:0] RND_HALF = 40'h0000008000;
	localparam logic [15:0] RND_TIE = 16'h8000;
	localparam logic [39:0] POS_MAX40 = 40'h7fffffffff;
	localparam logic [39:0] NEG_MAX40 = 40'h8000000000;
	localparam logic [39:0] POS_MAX32 = 40'h007fffffff;
	localparam logic [39:0] NEG_MAX32 = 40'hff80000000;
	localparam logic [31:0] FRAC_MAX = 32'h7fffffff;
	localparam logic [31:0] PROD_HALF = 32'h00008000;
	localparam logic [15:0] MOST_NEG16 = 16'h8000;
	localparam logic [5:0] SHC_RESET = 6'h00;
endpackage

// >>> src/dau_bit_if.sv
// connection between the datapath top and the bit manipulation unit
`timescale 1ns/1ps
`default_nettype none
interface dau_bit_if;
	logic [15:0] src_word;
	logic [7:0] mask;
	logic [1:0] mask_mode;
	logic [1:0] op;
	logic [15:0] result;
	logic test_ok;
	modport core(output src_word, output mask, output mask_mode, output op,
		input result, input test_ok);
	modport unit(input src_word, input mask, input mask_mode, input op,
		output result, output test_ok);
endinterface
`default_nettype wire

// >>> src/dau_bit_unit.sv
// masked bit test, set and clear on a 16-bit word
`timescale 1ns/1ps
`default_nettype none
module dau_bit_unit (
	dau_bit_if.unit bus
);
	logic [15:0] mask16;
	logic [15:0] hit;

	// RQ18 mask widening
	always_comb begin
		unique case (bus.mask_mode)
			dau_pkg::MASK_HIGH: mask16 = {bus.mask, 8'h00};
			dau_pkg::MASK_LOW: mask16 = {8'h00, bus.mask};
			dau_pkg::MASK_BOTH: mask16 = {bus.mask, bus.mask};
			default: mask16 = 16'h0000;
		endcase
	end

	assign hit = bus.src_word & mask16;

	// RQ17 per-bit operations
	always_comb begin
		bus.result = bus.src_word;
		bus.test_ok = 1'b0;
		unique case (bus.op)
			dau_pkg::BOP_TEST_LOW: begin
				bus.test_ok = (hit == 16'h0000);
			end
			dau_pkg::BOP_TEST_HIGH: begin
				bus.test_ok = (hit == mask16);
			end
			dau_pkg::BOP_HIGH_SET: begin
				bus.test_ok = (hit == mask16);
				bus.result = bus.src_word | mask16;
			end
			dau_pkg::BOP_LOW_CLEAR: begin
				bus.test_ok = (hit == 16'h0000);
				bus.result = bus.src_word & ~mask16;
			end
		endcase
	end
endmodule
`default_nettype wire

// >>> src/dau_alu_top.sv
// 40-bit alu, multiplier result path and bit unit behind an apb slave
`timescale 1ns/1ps
`default_nettype none
module dau_alu_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	localparam int unsigned MSB = dau_pkg::ACC_W - 1;
	localparam int unsigned WMSB = dau_pkg::WORD_W - 1;
	localparam int unsigned HMSB = dau_pkg::HALF_W - 1;

	logic [5:0] ctrl_q, ctrl_d;
	logic [7:0] cmd_q, cmd_d;
	logic [31:0] shift_lo_q, shift_lo_d;
	logic [7:0] shift_ext_q, shift_ext_d;
	logic [1:0][15:0] rin_q, rin_d;
	logic [1:0][39:0] acc_q, acc_d;
	logic [5:0] ccr_q, ccr_d;
	logic [31:0] prod_q, prod_d;
	logic [15:0] ph_q, ph_d;
	logic [5:0] bsc_q, bsc_d;
	logic [5:0] psc_q, psc_d;
	logic [31:0] mops_q, mops_d;
	logic [15:0] bdata_q, bdata_d;
	logic [15:0] bcmd_q, bcmd_d;
	logic [31:0] prdata_q, prdata_d;

	logic wr_en, rd_setup, hit;
	logic [31:0] rdata;
	logic [3:0] op;
	logic dsel, lacc;
	logic [1:0] rsel;
	logic [39:0] left_v, right_v, dst_v, a_v, b_v, bb, res, logic_v;
	logic [31:0] rword;
	logic [15:0] rhalf;
	logic [40:0] wide;
	logic sub, arith, sat_ok, wr_acc, wr_ccr, ovf, sign_true, fits32, sat_hit;
	logic signed [16:0] ma, mb;
	logic signed [33:0] mprod;
	logic [31:0] pval, pround;
	logic [1:0] b_amode, b_rsel;
	logic [15:0] b_reg;

	dau_bit_if bit_bus();

	dau_bit_unit u_bit (
		.bus(bit_bus)
	);

	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata = prdata_q;

	// read decode
	always_comb begin
		hit = 1'b1;
		rdata = 32'h00000000;
		unique case (paddr)
			dau_pkg::OFF_CTRL: rdata = {26'h0, ctrl_q};
			dau_pkg::OFF_CMD: rdata = {24'h0, cmd_q};
			dau_pkg::OFF_SHIFT_LO: rdata = shift_lo_q;
			dau_pkg::OFF_SHIFT_EXT: rdata = {24'h0, shift_ext_q};
			dau_pkg::OFF_RIGHT0: rdata = {16'h0, rin_q[0]};
			dau_pkg::OFF_RIGHT1: rdata = {16'h0, rin_q[1]};
			dau_pkg::OFF_ACC0_EXT: rdata = {24'h0, acc_q[0][MSB -: dau_pkg::EXT_W]};
			dau_pkg::OFF_ACC0_HI: rdata = {16'h0, acc_q[0][WMSB -: dau_pkg::HALF_W]};
			dau_pkg::OFF_ACC0_LO: rdata = {16'h0, acc_q[0][HMSB:0]};
			dau_pkg::OFF_ACC1_EXT: rdata = {24'h0, acc_q[1][MSB -: dau_pkg::EXT_W]};
			dau_pkg::OFF_ACC1_HI: rdata = {16'h0, acc_q[1][WMSB -: dau_pkg::HALF_W]};
			dau_pkg::OFF_ACC1_LO: rdata = {16'h0, acc_q[1][HMSB:0]};
			dau_pkg::OFF_CCR: rdata = {26'h0, ccr_q};
			dau_pkg::OFF_PRODUCT: rdata = prod_q;
			dau_pkg::OFF_PROD_HIGH: rdata = {16'h0, ph_q};
			dau_pkg::OFF_SHIFT_CTRL: rdata = {26'h0, bsc_q};
			dau_pkg::OFF_PROD_SHIFT: rdata = {26'h0, psc_q};
			dau_pkg::OFF_MUL_OPS: rdata = mops_q;
			dau_pkg::OFF_BIT_DATA: rdata = {16'h0, bdata_q};
			dau_pkg::OFF_BIT_CMD: rdata = {16'h0, bcmd_q};
			default: hit = 1'b0;
		endcase
	end

	// alu operand selection and result
	always_comb begin
		op = pwdata[dau_pkg::CMD_OP_LSB +: dau_pkg::OP_W];
		dsel = pwdata[dau_pkg::CMD_DEST];
		rsel = pwdata[dau_pkg::CMD_RSEL_LSB +: 2];
		lacc = pwdata[dau_pkg::CMD_LEFT_ACC];
		// RQ2 left from shifter
		left_v = lacc ? {shift_ext_q, shift_lo_q} :
			{{dau_pkg::EXT_W{shift_lo_q[WMSB]}}, shift_lo_q};
		rhalf = rin_q[rsel[0]];
		rword = ctrl_q[dau_pkg::CTRL_RIGHT_LONG] ? {rin_q[1], rin_q[0]} : {rhalf, 16'h0000};
		// RQ4 RQ5 operand extension
		right_v = rsel[1] ? acc_q[rsel[0]] : {{dau_pkg::EXT_W{rword[WMSB]}}, rword};
		dst_v = acc_q[dsel];
		a_v = left_v;
		b_v = right_v;
		sub = 1'b0;
		arith = 1'b1;
		sat_ok = 1'b1;
		wr_acc = 1'b1;
		wr_ccr = 1'b1;
		logic_v = 40'h0;
		// RQ6 RQ7 operand groups and targets
		unique case (op)
			dau_pkg::OP_ADD: ;
			dau_pkg::OP_SUB: sub = 1'b1;
			dau_pkg::OP_CMP: begin
				sub = 1'b1;
				wr_acc = 1'b0;
			end
			// RQ3 logical ops zero-extended
			dau_pkg::OP_AND: begin
				arith = 1'b0;
				logic_v = {8'h00, left_v[WMSB:0] & right_v[WMSB:0]};
			end
			dau_pkg::OP_OR: begin
				arith = 1'b0;
				logic_v = {8'h00, left_v[WMSB:0] | right_v[WMSB:0]};
			end
			dau_pkg::OP_XOR: begin
				arith = 1'b0;
				logic_v = {8'h00, left_v[WMSB:0] ^ right_v[WMSB:0]};
			end
			dau_pkg::OP_NOT: begin
				arith = 1'b0;
				logic_v = {8'h00, ~dst_v[WMSB:0]};
			end
			dau_pkg::OP_MOVE: begin
				a_v = 40'h0;
				sat_ok = 1'b0;
				wr_ccr = 1'b0;
			end
			dau_pkg::OP_NEG: begin
				a_v = 40'h0;
				sub = 1'b1;
			end
			dau_pkg::OP_ABS: begin
				a_v = 40'h0;
				sub = right_v[MSB];
			end
			// RQ15 rounding increment
			dau_pkg::OP_RND: begin
				a_v = dst_v;
				b_v = (ctrl_q[dau_pkg::CTRL_RND_MODE] && dst_v[HMSB:0] == dau_pkg::RND_TIE &&
					!dst_v[dau_pkg::HALF_W]) ? 40'h0 : dau_pkg::RND_HALF;
			end
			// RQ8 non-restoring division step
			dau_pkg::OP_DIVS: begin
				a_v = {dst_v[MSB-1:0], 1'b0};
				b_v = {{dau_pkg::EXT_W{rhalf[HMSB]}}, rhalf, 16'h0000};
				sub = (dst_v[MSB] == rhalf[HMSB]);
				sat_ok = 1'b0;
			end
			dau_pkg::OP_DIVU: begin
				a_v = {dst_v[MSB-1:0], 1'b0};
				b_v = {8'h00, rhalf, 16'h0000};
				sub = ~dst_v[MSB];
				sat_ok = 1'b0;
			end
			default: begin
				arith = 1'b0;
				wr_acc = 1'b0;
				wr_ccr = 1'b0;
			end
		endcase
		bb = sub ? ~b_v : b_v;
		// RQ1 RQ21 40-bit modular sum
		wide = {1'b0, a_v} + {1'b0, bb} + {40'h0, sub};
		ovf = arith & (a_v[MSB] == bb[MSB]) & (wide[MSB] != a_v[MSB]);
		sign_true = ovf ? a_v[MSB] : wide[MSB];
		fits32 = (&wide[MSB:WMSB]) | ~(|wide[MSB:WMSB]);
		sat_hit = ctrl_q[dau_pkg::CTRL_SAT_EN] & sat_ok & arith &
			(ovf | (~ctrl_q[dau_pkg::CTRL_SAT_WIDTH] & ~fits32));
		res = arith ? wide[MSB:0] : logic_v;
		// RQ13 saturation clamp
		if (sat_hit) begin
			if (ctrl_q[dau_pkg::CTRL_SAT_WIDTH]) begin
				res = sign_true ? dau_pkg::NEG_MAX40 : dau_pkg::POS_MAX40;
			end else begin
				res = sign_true ? dau_pkg::NEG_MAX32 : dau_pkg::POS_MAX32;
			end
		end else if (op == dau_pkg::OP_RND) begin
			res[HMSB:0] = 16'h0000;
		end
		if (op == dau_pkg::OP_DIVS) begin
			res[0] = (wide[MSB] == rhalf[HMSB]);
		end else if (op == dau_pkg::OP_DIVU) begin
			res[0] = ~wide[MSB];
		end
	end

	// multiplier result path
	always_comb begin
		ma = {ctrl_q[dau_pkg::CTRL_MUL_SIGNED] & mops_q[WMSB], mops_q[WMSB -: dau_pkg::HALF_W]};
		mb = {ctrl_q[dau_pkg::CTRL_MUL_SIGNED] & mops_q[HMSB], mops_q[HMSB:0]};
		mprod = ma * mb;
		pval = ctrl_q[dau_pkg::CTRL_MUL_INT] ? mprod[WMSB:0] : {mprod[WMSB-1:0], 1'b0};
		// RQ12 most-negative square clamp
		if (ctrl_q[dau_pkg::CTRL_SAT_EN] && ctrl_q[dau_pkg::CTRL_MUL_SIGNED] &&
			!ctrl_q[dau_pkg::CTRL_MUL_INT] && mops_q[WMSB -: dau_pkg::HALF_W] == dau_pkg::MOST_NEG16 &&
			mops_q[HMSB:0] == dau_pkg::MOST_NEG16) begin
			pval = dau_pkg::FRAC_MAX;
		end
		pround = pval + dau_pkg::PROD_HALF;
	end

	// RQ16 RQ19 bit unit source selection
	assign b_amode = pwdata[dau_pkg::BC_AMODE_LSB +: 2];
	assign b_rsel = pwdata[dau_pkg::BC_RSEL_LSB +: 2];
	always_comb begin
		unique case (b_rsel)
			dau_pkg::BREG_ACC0_EXT: b_reg = {{8{acc_q[0][MSB]}}, acc_q[0][MSB -: dau_pkg::EXT_W]};
			dau_pkg::BREG_ACC1_EXT: b_reg = {{8{acc_q[1][MSB]}}, acc_q[1][MSB -: dau_pkg::EXT_W]};
			dau_pkg::BREG_SHIFT_CTRL: b_reg = {{10{bsc_q[dau_pkg::SHC_W-1]}}, bsc_q};
			dau_pkg::BREG_PROD_SHIFT: b_reg = {{10{psc_q[dau_pkg::SHC_W-1]}}, psc_q};
		endcase
	end
	assign bit_bus.src_word = (b_amode == dau_pkg::AMODE_REGISTER) ? b_reg : bdata_q;
	assign bit_bus.mask = pwdata[dau_pkg::BC_MASK_LSB +: 8];
	assign bit_bus.mask_mode = pwdata[dau_pkg::BC_MMODE_LSB +: 2];
	assign bit_bus.op = pwdata[dau_pkg::BC_OP_LSB +: 2];

	// next state of all registers
	always_comb begin
		ctrl_d = ctrl_q;
		cmd_d = cmd_q;
		shift_lo_d = shift_lo_q;
		shift_ext_d = shift_ext_q;
		rin_d = rin_q;
		acc_d = acc_q;
		ccr_d = ccr_q;
		prod_d = prod_q;
		ph_d = ph_q;
		bsc_d = bsc_q;
		psc_d = psc_q;
		mops_d = mops_q;
		bdata_d = bdata_q;
		bcmd_d = bcmd_q;
		prdata_d = rd_setup ? rdata : prdata_q;
		if (wr_en) begin
			unique case (paddr)
				dau_pkg::OFF_CTRL: ctrl_d = pwdata[dau_pkg::CTRL_W-1:0];
				dau_pkg::OFF_CMD: begin
					cmd_d = pwdata[dau_pkg::CMD_W-1:0];
					if (wr_acc) begin
						acc_d[dsel] = res;
					end
					if (wr_ccr) begin
						ccr_d[dau_pkg::CCR_CARRY] = arith & wide[dau_pkg::ACC_W];
						ccr_d[dau_pkg::CCR_OVF] = ovf;
						ccr_d[dau_pkg::CCR_ZERO] = (res == 40'h0);
						ccr_d[dau_pkg::CCR_NEG] = res[MSB];
						ccr_d[dau_pkg::CCR_LIMIT] = ccr_q[dau_pkg::CCR_LIMIT] | sat_hit;
					end
					// RQ14 rounded product high
					if (op == dau_pkg::OP_MUL || op == dau_pkg::OP_MULR) begin
						prod_d = pval;
						ph_d = (op == dau_pkg::OP_MULR) ? pround[WMSB -: dau_pkg::HALF_W] :
							pval[WMSB -: dau_pkg::HALF_W];
					end
				end
				dau_pkg::OFF_SHIFT_LO: shift_lo_d = pwdata;
				dau_pkg::OFF_SHIFT_EXT: shift_ext_d = pwdata[7:0];
				dau_pkg::OFF_RIGHT0: rin_d[0] = pwdata[HMSB:0];
				dau_pkg::OFF_RIGHT1: rin_d[1] = pwdata[HMSB:0];
				// RQ20 separate field writes
				dau_pkg::OFF_ACC0_EXT: acc_d[0][MSB -: dau_pkg::EXT_W] = pwdata[7:0];
				dau_pkg::OFF_ACC0_HI: acc_d[0][WMSB -: dau_pkg::HALF_W] = pwdata[HMSB:0];
				dau_pkg::OFF_ACC0_LO: acc_d[0][HMSB:0] = pwdata[HMSB:0];
				dau_pkg::OFF_ACC1_EXT: acc_d[1][MSB -: dau_pkg::EXT_W] = pwdata[7:0];
				dau_pkg::OFF_ACC1_HI: acc_d[1][WMSB -: dau_pkg::HALF_W] = pwdata[HMSB:0];
				dau_pkg::OFF_ACC1_LO: acc_d[1][HMSB:0] = pwdata[HMSB:0];
				dau_pkg::OFF_CCR: ccr_d = pwdata[dau_pkg::CCR_W-1:0];
				dau_pkg::OFF_PROD_HIGH: ph_d = pwdata[HMSB:0];
				dau_pkg::OFF_SHIFT_CTRL: bsc_d = pwdata[dau_pkg::SHC_W-1:0];
				dau_pkg::OFF_PROD_SHIFT: psc_d = pwdata[dau_pkg::SHC_W-1:0];
				dau_pkg::OFF_MUL_OPS: mops_d = pwdata;
				dau_pkg::OFF_BIT_DATA: bdata_d = pwdata[HMSB:0];
				dau_pkg::OFF_BIT_CMD: begin
					// RQ17 bit test result and write-back
					bcmd_d = pwdata[dau_pkg::BC_W-1:0];
					ccr_d[dau_pkg::CCR_TEST] = bit_bus.test_ok;
					if (b_amode != dau_pkg::AMODE_REGISTER) begin
						bdata_d = bit_bus.result;
					end else begin
						unique case (b_rsel)
							dau_pkg::BREG_ACC0_EXT: acc_d[0][MSB -: dau_pkg::EXT_W] = bit_bus.result[7:0];
							dau_pkg::BREG_ACC1_EXT: acc_d[1][MSB -: dau_pkg::EXT_W] = bit_bus.result[7:0];
							dau_pkg::BREG_SHIFT_CTRL: bsc_d = bit_bus.result[dau_pkg::SHC_W-1:0];
							dau_pkg::BREG_PROD_SHIFT: psc_d = bit_bus.result[dau_pkg::SHC_W-1:0];
						endcase
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 6'h00;
			cmd_q <= 8'h00;
			shift_lo_q <= 32'h00000000;
			shift_ext_q <= 8'h00;
			rin_q <= 32'h00000000;
			acc_q <= 80'h0;
			ccr_q <= 6'h00;
			prod_q <= 32'h00000000;
			ph_q <= 16'h0000;
			bsc_q <= dau_pkg::SHC_RESET;
			psc_q <= dau_pkg::SHC_RESET;
			mops_q <= 32'h00000000;
			bdata_q <= 16'h0000;
			bcmd_q <= 16'h0000;
			prdata_q <= 32'h00000000;
		end else begin
			ctrl_q <= ctrl_d;
			cmd_q <= cmd_d;
			shift_lo_q <= shift_lo_d;
			shift_ext_q <= shift_ext_d;
			rin_q <= rin_d;
			acc_q <= acc_d;
			ccr_q <= ccr_d;
			prod_q <= prod_d;
			ph_q <= ph_d;
			bsc_q <= bsc_d;
			psc_q <= psc_d;
			mops_q <= mops_d;
			bdata_q <= bdata_d;
			bcmd_q <= bcmd_d;
			prdata_q <= prdata_d;
		end
	end
endmodule
`default_nettype wire

// >>> sim/dau_alu_sva.sv
// port checker for the alu datapath top
`timescale 1ns/1ps
`default_nettype none
module dau_alu_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic rd;
	assign rd = psel && penable && !pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ext; rd && paddr == dau_pkg::OFF_ACC0_EXT |-> prdata[31:8] == 24'h0; endproperty
	a_ext: assert property (p_ext) else $error("ext too wide");
	property p_hi; rd && paddr == dau_pkg::OFF_ACC0_HI |-> prdata[31:16] == 16'h0; endproperty
	a_hi: assert property (p_hi) else $error("acc half too wide");
	property p_right; rd && paddr == dau_pkg::OFF_RIGHT0 |-> prdata[31:16] == 16'h0; endproperty
	a_right: assert property (p_right) else $error("right reg too wide");
	property p_ph; rd && paddr == dau_pkg::OFF_PROD_HIGH |-> prdata[31:16] == 16'h0; endproperty
	a_ph: assert property (p_ph) else $error("product high too wide");
	property p_shc; rd && paddr == dau_pkg::OFF_SHIFT_CTRL |-> prdata[31:6] == 26'h0; endproperty
	a_shc: assert property (p_shc) else $error("shift ctrl too wide");
	property p_psc; rd && paddr == dau_pkg::OFF_PROD_SHIFT |-> prdata[31:6] == 26'h0; endproperty
	a_psc: assert property (p_psc) else $error("prod shift too wide");
	property p_ccr; rd && paddr == dau_pkg::OFF_CCR |-> prdata[31:6] == 26'h0; endproperty
	a_ccr: assert property (p_ccr) else $error("flags too wide");
	property p_bus;
		psel && penable |-> pready && pslverr == (paddr > dau_pkg::OFF_BIT_CMD || paddr[1:0] != 2'h0);
	endproperty
	a_bus: assert property (p_bus) else $error("bad answer");
	property p_idle; !(psel && penable) |-> !pslverr; endproperty
	a_idle: assert property (p_idle) else $error("error outside access");
endmodule
bind dau_alu_top dau_alu_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));
`default_nettype wire

// >>> sim/dau_apb_master.sv
// apb master model standing for the core decoder side
`timescale 1ns/1ps
`default_nettype none
module dau_apb_master (
	input wire logic pclk,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [7:0] paddr = 8'h0,
	output logic [31:0] pwdata = 32'h0,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	int tmo = 0;
	// one transfer; released lines show inverted values
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (!pready && n < 20);
		tmo += int'(pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// >>> sim/dau_alu_top_bench.sv
// self-checking bench for the alu datapath top
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x, s) begin compares++; if ((g) !== (x)) begin \
	fails++; $display("[FAIL] %0t %s", $time, s); end end
module dau_alu_top_bench;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	int fails = 0;
	int compares = 0;
	dau_alu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	dau_apb_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic end_sim();
		fails += m.tmo;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		m.xfer(1'b1, a, d, q, e);
		if (m.tmo != 0)
			end_sim();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		m.xfer(1'b0, a, 32'h0, q, e);
		if (m.tmo != 0)
			end_sim();
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] x, input string s);
		logic [31:0] q;
		rd(a, q);
		`CHK(q, x, s)
	endtask
	task automatic cmd(input logic [3:0] hi, input logic [3:0] op);
		wr(dau_pkg::OFF_CMD, {24'h0, hi, op});
	endtask
	task automatic set_acc(input logic [7:0] b, input logic [39:0] v);
		wr(b, {24'h0, v[39:32]});
		wr(b + 8'h4, {16'h0, v[31:16]});
		wr(b + 8'h8, {16'h0, v[15:0]});
	endtask
	task automatic acc_chk(input logic [39:0] x, input string s);
		logic [31:0] e;
		logic [31:0] h;
		logic [31:0] l;
		rd(dau_pkg::OFF_ACC0_EXT, e);
		rd(dau_pkg::OFF_ACC0_HI, h);
		rd(dau_pkg::OFF_ACC0_LO, l);
		`CHK({e[7:0], h[15:0], l[15:0]}, x, s)
	endtask
	task automatic flag_chk(input int b, input logic x, input string s);
		logic [31:0] q;
		rd(dau_pkg::OFF_CCR, q);
		`CHK(q[b], x, s)
	endtask
	task automatic t_reset();
		logic [31:0] q;
		logic e;
		acc_chk(40'h0, "acc reset");
		chk(dau_pkg::OFF_SHIFT_CTRL, 32'h0, "shift ctrl reset");
		chk(dau_pkg::OFF_PROD_SHIFT, 32'h0, "prod shift reset");
		chk(dau_pkg::OFF_RIGHT0, 32'h0, "right reset");
		chk(dau_pkg::OFF_CCR, 32'h0, "flags reset");
		wr(dau_pkg::OFF_PRODUCT, 32'h12345678);
		chk(dau_pkg::OFF_PRODUCT, 32'h0, "product read only");
		m.xfer(1'b0, 8'h50, 32'h0, q, e);
		`CHK({e, q}, 33'h100000000, "unmapped")
		$display("reset done");
	endtask
	task automatic t_logic();
		logic [3:0] op [3] = '{dau_pkg::OP_AND, dau_pkg::OP_OR, dau_pkg::OP_XOR};
		logic [31:0] ex [3] = '{32'h8f0f0000, 32'hffff1234, 32'h70f01234};
		wr(dau_pkg::OFF_SHIFT_LO, 32'hffff1234);
		wr(dau_pkg::OFF_RIGHT0, 32'h00008f0f);
		for (int i = 0; i < 3; i++) begin
			set_acc(dau_pkg::OFF_ACC0_EXT, 40'h5a00000000);
			cmd(4'h0, op[i]);
			acc_chk({8'h0, ex[i]}, "logic op");
		end
		$display("logic done");
	endtask
	task automatic t_arith();
		logic [31:0] cv [3] = '{32'h0, 32'h3, 32'h1};
		logic [39:0] ex [3] = '{40'h8000000000, 40'h7fffffffff, 40'h007fffffff};
		wr(dau_pkg::OFF_CTRL, 32'h0);
		wr(dau_pkg::OFF_SHIFT_LO, 32'h80000000);
		wr(dau_pkg::OFF_RIGHT0, 32'h00008000);
		cmd(4'h0, dau_pkg::OP_ADD);
		acc_chk(40'hff00000000, "sign extend add");
		wr(dau_pkg::OFF_SHIFT_EXT, 32'h7f);
		wr(dau_pkg::OFF_SHIFT_LO, 32'hffffffff);
		set_acc(dau_pkg::OFF_ACC1_EXT, 40'h1);
		for (int i = 0; i < 3; i++) begin
			wr(dau_pkg::OFF_CTRL, cv[i]);
			cmd(4'he, dau_pkg::OP_ADD);
			acc_chk(ex[i], "overflow");
		end
		flag_chk(dau_pkg::CCR_OVF, 1'b1, "overflow flag");
		$display("arith done");
	endtask
	task automatic t_flags();
		set_acc(dau_pkg::OFF_ACC0_EXT, 40'h0011112222);
		wr(dau_pkg::OFF_SHIFT_LO, 32'h00050000);
		wr(dau_pkg::OFF_RIGHT0, 32'h5);
		wr(dau_pkg::OFF_CCR, 32'h0);
		cmd(4'h0, dau_pkg::OP_CMP);
		acc_chk(40'h0011112222, "compare keeps acc");
		flag_chk(dau_pkg::CCR_ZERO, 1'b1, "compare zero");
		wr(dau_pkg::OFF_CCR, 32'h0);
		cmd(4'h0, dau_pkg::OP_MOVE);
		chk(dau_pkg::OFF_CCR, 32'h0, "move keeps flags");
		set_acc(dau_pkg::OFF_ACC0_EXT, 40'h1200ff0f0f);
		cmd(4'h0, dau_pkg::OP_NOT);
		acc_chk(40'h00ff00f0f0, "one operand");
		cmd(4'h0, dau_pkg::OP_NEG);
		acc_chk(40'hfffffb0000, "negate");
		cmd(4'h4, dau_pkg::OP_ABS);
		acc_chk(40'h0000050000, "absolute");
		$display("flags done");
	endtask
	task automatic t_div();
		logic [3:0] op [2] = '{dau_pkg::OP_DIVS, dau_pkg::OP_DIVU};
		wr(dau_pkg::OFF_CTRL, 32'h0);
		wr(dau_pkg::OFF_RIGHT0, 32'h00004000);
		for (int i = 0; i < 2; i++) begin
			set_acc(dau_pkg::OFF_ACC0_EXT, 40'h0030000000);
			cmd(4'h0, op[i]);
			acc_chk(40'h0020000001, "division step");
		end
		$display("div done");
	endtask
	task automatic t_rnd();
		logic [31:0] cv [2] = '{32'h0, 32'h4};
		logic [39:0] ex [2] = '{40'h0000030000, 40'h0000020000};
		for (int i = 0; i < 2; i++) begin
			set_acc(dau_pkg::OFF_ACC0_EXT, 40'h0000028000);
			wr(dau_pkg::OFF_CTRL, cv[i]);
			cmd(4'h0, dau_pkg::OP_RND);
			acc_chk(ex[i], "acc rounding");
		end
		$display("round done");
	endtask
	task automatic t_mul();
		wr(dau_pkg::OFF_CTRL, 32'h11);
		wr(dau_pkg::OFF_MUL_OPS, 32'h80008000);
		cmd(4'h0, dau_pkg::OP_MUL);
		chk(dau_pkg::OFF_PRODUCT, 32'h7fffffff, "product clamp");
		wr(dau_pkg::OFF_MUL_OPS, 32'h40000101);
		cmd(4'h0, dau_pkg::OP_MULR);
		chk(dau_pkg::OFF_PROD_HIGH, 32'h0081, "rounded product");
		$display("mul done");
	endtask
	task automatic t_bit();
		logic [15:0] c [5] = '{16'h040f, 16'h110f, 16'h0a0f, 16'h1c0f, 16'ha480};
		logic t [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		logic [15:0] d [5] = '{16'h0f00, 16'h0f00, 16'h0f0f, 16'h000f, 16'h000f};
		wr(dau_pkg::OFF_SHIFT_CTRL, 32'h20);
		wr(dau_pkg::OFF_BIT_DATA, 32'h0f00);
		for (int i = 0; i < 5; i++) begin
			wr(dau_pkg::OFF_BIT_CMD, {16'h0, c[i]});
			flag_chk(dau_pkg::CCR_TEST, t[i], "bit test");
			chk(dau_pkg::OFF_BIT_DATA, {16'h0, d[i]}, "bit data");
		end
		$display("bit done");
	endtask
	initial begin
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_logic();
		t_arith();
		t_flags();
		t_div();
		t_rnd();
		t_mul();
		t_bit();
		end_sim();
	end
endmodule
`default_nettype wire
